// >>> esd_event_sources.sv
// event source block: level detectors, level combiner, port edge detectors, prioritized combiner
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`include "esd_consts.svh"

module esd_event_sources
  import esd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ESD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // post-processed sample streams
  input wire logic [`ESD_NCH*`ESD_SW-1:0] chan_samples,
  input wire logic [`ESD_NCH-1:0] chan_valid,
  input wire logic acq_running,
  // external port comparator outputs
  input wire logic [`ESD_OVS-1:0] fine_timing_port,
  input wire logic coarse_timing_port,
  input wire logic general_port_a,
  input wire logic backplane_star_source,
  input wire logic backplane_trig0_source,
  input wire logic backplane_trig1_source,
  // comparator thresholds
  output logic [`ESD_SW-1:0] fine_threshold,
  output logic [`ESD_SW-1:0] coarse_threshold,
  // record trigger consumers
  output logic [`ESD_NCH-1:0] chan_level_rise,
  output logic [`ESD_NCH-1:0] chan_level_fall,
  output logic level_matrix_rise,
  output logic level_matrix_fall,
  output logic [2:0] fine_subsample_pos,
  // pulse generator and function module consumers
  output logic pulse_level_matrix_rise,
  output logic pulse_level_matrix_fall,
  output logic matrix_rise,
  output logic matrix_fall,
  output logic [1:0] matrix_input
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [`ESD_NCH*`ESD_LM_FIELD_W-1:0] lmatrix_q;
  logic [`ESD_NMX*`ESD_MX_FIELD_W-1:0] matrix_q;
  logic [`ESD_SW-1:0] fine_thr_q;
  logic [`ESD_SW-1:0] coarse_thr_q;
  logic [`ESD_SW-1:0] level_q [`ESD_NCH];
  logic [`ESD_SW-1:0] hyst_q [`ESD_NCH];
  logic soft_q;
  logic [31:0] prdata_q;
  logic err_q;
  logic [31:0] rd_d;
  logic hit_d;
  logic wr_en;
  logic setup;
  logic [`ESD_NCH-1:0] rise_armed;
  logic [`ESD_NCH-1:0] fall_armed;
  logic [1:0] last_winner_q;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;

  // decode shared by read data and the error answer
  always_comb
  begin
    rd_d = 32'h00000000;
    hit_d = 1'b1;
    case (paddr)
      `ESD_OFS_STATUS: rd_d = {22'h000000, last_winner_q, fall_armed, rise_armed};
      `ESD_OFS_LMATRIX: rd_d = {20'h00000, lmatrix_q};
      `ESD_OFS_MATRIX: rd_d = {12'h000, matrix_q};
      `ESD_OFS_SOFT: rd_d = 32'h00000000;
      `ESD_OFS_FINE_THR: rd_d = {16'h0000, fine_thr_q};
      `ESD_OFS_COARSE_THR: rd_d = {16'h0000, coarse_thr_q};
      default:
      begin
        hit_d = 1'b0;
        for (int c = 0; c < `ESD_NCH; c++)
        begin
          if (paddr == `ESD_OFS_LEVEL0 + `ESD_ADDR_W'(c) * `ESD_CH_STRIDE)
          begin
            rd_d = {16'h0000, level_q[c]};
            hit_d = 1'b1;
          end
          if (paddr == `ESD_OFS_HYST0 + `ESD_ADDR_W'(c) * `ESD_CH_STRIDE)
          begin
            rd_d = {16'h0000, hyst_q[c]};
            hit_d = 1'b1;
          end
        end
      end
    endcase
  end

  // answer prepared in setup so read data comes from flops
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      prdata_q <= 32'h00000000;
      err_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q <= pwrite ? 32'h00000000 : rd_d;
      err_q <= !hit_d;
    end
  end

  assign pready = psel && penable;
  assign pslverr = psel && penable && err_q;
  assign prdata = prdata_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      lmatrix_q <= `ESD_LMATRIX_RST;
      matrix_q <= `ESD_MATRIX_RST;
      fine_thr_q <= `ESD_THR_RST;
      coarse_thr_q <= `ESD_THR_RST;
    end
    else if (wr_en && !err_q)
    begin
      if (paddr == `ESD_OFS_LMATRIX)
        lmatrix_q <= pwdata[`ESD_NCH*`ESD_LM_FIELD_W-1:0];
      if (paddr == `ESD_OFS_MATRIX)
        matrix_q <= pwdata[`ESD_NMX*`ESD_MX_FIELD_W-1:0];
      if (paddr == `ESD_OFS_FINE_THR)
        fine_thr_q <= pwdata[`ESD_SW-1:0];
      if (paddr == `ESD_OFS_COARSE_THR)
        coarse_thr_q <= pwdata[`ESD_SW-1:0];
    end
  end

  // per-channel threshold and margin, independent settings
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int c = 0; c < `ESD_NCH; c++)
      begin
        level_q[c] <= `ESD_THR_RST;
        hyst_q[c] <= `ESD_HYST_RST;
      end
    end
    else if (wr_en && !err_q)
    begin
      for (int c = 0; c < `ESD_NCH; c++)
      begin
        if (paddr == `ESD_OFS_LEVEL0 + `ESD_ADDR_W'(c) * `ESD_CH_STRIDE)
          level_q[c] <= pwdata[`ESD_SW-1:0];
        if (paddr == `ESD_OFS_HYST0 + `ESD_ADDR_W'(c) * `ESD_CH_STRIDE)
          hyst_q[c] <= pwdata[`ESD_SW-1:0];
      end
    end
  end

  // software event: one pulse per write with bit 0 set, rising polarity only
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      soft_q <= 1'b0;
    else
      soft_q <= wr_en && !err_q && (paddr == `ESD_OFS_SOFT) && pwdata[0];
  end

  assign fine_threshold = fine_thr_q;
  assign coarse_threshold = coarse_thr_q;

  // ----------------------------------------------------------------
  // level detectors and level combiner
  // ----------------------------------------------------------------
  logic [`ESD_NCH-1:0] lv_rise;
  logic [`ESD_NCH-1:0] lv_fall;
  logic lm_rise_q;
  logic lm_fall_q;
  logic lm_rise_d;
  logic lm_fall_d;

  for (genvar g = 0; g < `ESD_NCH; g++)
  begin : g_level
    esd_level_det u_det (
      .clk(clk),
      .reset(reset),
      .sample(chan_samples[g*`ESD_SW +: `ESD_SW]),
      .sample_valid(chan_valid[g]),
      .acq_running(acq_running),
      .threshold(level_q[g]),
      .hysteresis(hyst_q[g]),
      .rise_evt(lv_rise[g]),
      .fall_evt(lv_fall[g]),
      .rise_armed(rise_armed[g]),
      .fall_armed(fall_armed[g])
    );
  end

  // dedicated channel events reach record triggering and nothing else
  assign chan_level_rise = lv_rise;
  assign chan_level_fall = lv_fall;

  // field per channel: bit 0 enable, bits 2:1 edge
  always_comb
  begin
    lm_rise_d = 1'b0;
    lm_fall_d = 1'b0;
    for (int c = 0; c < `ESD_NCH; c++)
    begin
      if (lmatrix_q[c*`ESD_LM_FIELD_W])
      begin
        lm_rise_d = lm_rise_d | esd_edge_match(lmatrix_q[c*`ESD_LM_FIELD_W+1 +: 2], lv_rise[c], 1'b0);
        lm_fall_d = lm_fall_d | esd_edge_match(lmatrix_q[c*`ESD_LM_FIELD_W+1 +: 2], 1'b0, lv_fall[c]);
      end
    end
  end

  // one register stage: two cycles from sample to output, always the same
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      lm_rise_q <= 1'b0;
      lm_fall_q <= 1'b0;
    end
    else
    begin
      lm_rise_q <= lm_rise_d;
      lm_fall_q <= lm_fall_d;
    end
  end

  assign level_matrix_rise = lm_rise_q;
  assign level_matrix_fall = lm_fall_q;
  assign pulse_level_matrix_rise = lm_rise_q;
  assign pulse_level_matrix_fall = lm_fall_q;

  // ----------------------------------------------------------------
  // fine timing port: eight oversampled bits per clock, bit 0 oldest
  // ----------------------------------------------------------------
  logic fine_last_q;
  logic fine_rise_q;
  logic fine_fall_q;
  logic [2:0] fine_pos_q;
  logic [`ESD_OVS:0] fine_seq;
  logic fine_rise_d;
  logic fine_fall_d;
  logic [2:0] fine_pos_d;

  assign fine_seq = {fine_timing_port, fine_last_q};

  // first transition in the word wins; a glitch inside one word is one event
  always_comb
  begin
    fine_rise_d = 1'b0;
    fine_fall_d = 1'b0;
    fine_pos_d = 3'h0;
    for (int i = `ESD_OVS - 1; i >= 0; i--)
    begin
      if (fine_seq[i+1] != fine_seq[i])
      begin
        fine_rise_d = fine_seq[i+1];
        fine_fall_d = !fine_seq[i+1];
        fine_pos_d = 3'(i);
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      fine_last_q <= 1'b0;
      fine_rise_q <= 1'b0;
      fine_fall_q <= 1'b0;
      fine_pos_q <= 3'h0;
    end
    else
    begin
      fine_last_q <= fine_timing_port[`ESD_OVS-1];
      fine_rise_q <= fine_rise_d;
      fine_fall_q <= fine_fall_d;
      fine_pos_q <= fine_pos_d;
    end
  end

  assign fine_subsample_pos = fine_pos_q;

  // ----------------------------------------------------------------
  // slow ports: sampled once every eight clocks
  // ----------------------------------------------------------------
  localparam int NSLOW = 5;
  logic [2:0] div_q;
  logic [NSLOW-1:0] slow_in;
  logic [NSLOW-1:0] slow_smp_q;
  logic [NSLOW-1:0] slow_rise_q;
  logic [NSLOW-1:0] slow_fall_q;

  assign slow_in = {backplane_trig1_source, backplane_trig0_source, backplane_star_source,
                    general_port_a, coarse_timing_port};

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end

  for (genvar s = 0; s < NSLOW; s++)
  begin : g_slow
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
      begin
        slow_smp_q[s] <= 1'b0;
        slow_rise_q[s] <= 1'b0;
        slow_fall_q[s] <= 1'b0;
      end
      else if (div_q == `ESD_SLOW_DIV)
      begin
        slow_smp_q[s] <= slow_in[s];
        slow_rise_q[s] <= slow_in[s] && !slow_smp_q[s];
        slow_fall_q[s] <= !slow_in[s] && slow_smp_q[s];
      end
      else
      begin
        slow_rise_q[s] <= 1'b0;
        slow_fall_q[s] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // prioritized combiner over external ports and software
  // ----------------------------------------------------------------
  logic [7:0] src_rise;
  logic [7:0] src_fall;
  logic mx_hit_d;
  logic mx_rise_d;
  logic mx_fall_d;
  logic [1:0] mx_idx_d;
  logic mx_rise_q;
  logic mx_fall_q;
  logic [1:0] mx_idx_q;

  // index by source code; code 0 carries nothing
  assign src_rise = {soft_q, slow_rise_q[4:1], slow_rise_q[0], fine_rise_q, 1'b0};
  assign src_fall = {1'b0, slow_fall_q[4:1], slow_fall_q[0], fine_fall_q, 1'b0};

  always_comb
  begin
    mx_hit_d = 1'b0;
    mx_rise_d = 1'b0;
    mx_fall_d = 1'b0;
    mx_idx_d = 2'h0;
    // walk from lowest priority up so input 0 lands last
    for (int m = `ESD_NMX - 1; m >= 0; m--)
    begin
      if (matrix_q[m*`ESD_MX_FIELD_W +: 3] != ESD_SRC_INVALID)
      begin
        if (esd_edge_match(matrix_q[m*`ESD_MX_FIELD_W+3 +: 2],
                           src_rise[matrix_q[m*`ESD_MX_FIELD_W +: 3]],
                           src_fall[matrix_q[m*`ESD_MX_FIELD_W +: 3]]))
        begin
          mx_hit_d = 1'b1;
          mx_rise_d = src_rise[matrix_q[m*`ESD_MX_FIELD_W +: 3]] &&
                      matrix_q[m*`ESD_MX_FIELD_W+3 +: 2] != ESD_EDGE_FALLING;
          mx_fall_d = src_fall[matrix_q[m*`ESD_MX_FIELD_W +: 3]] &&
                      matrix_q[m*`ESD_MX_FIELD_W+3 +: 2] != ESD_EDGE_RISING;
          mx_idx_d = 2'(m);
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mx_rise_q <= 1'b0;
      mx_fall_q <= 1'b0;
      mx_idx_q <= 2'h0;
      last_winner_q <= 2'h0;
    end
    else
    begin
      mx_rise_q <= mx_rise_d;
      mx_fall_q <= mx_fall_d;
      mx_idx_q <= mx_hit_d ? mx_idx_d : 2'h0;
      if (mx_hit_d)
        last_winner_q <= mx_idx_d;
    end
  end

  // separate from the level combiner; usable by triggers and functions
  assign matrix_rise = mx_rise_q;
  assign matrix_fall = mx_fall_q;
  assign matrix_input = mx_idx_q;

endmodule

// >>> esd_consts.svh
// offsets, field positions, reset values and timing counts of the event source block
`ifndef ESD_CONSTS_SVH
`define ESD_CONSTS_SVH

`define ESD_NCH 4
`define ESD_NMX 4
`define ESD_SW 16
`define ESD_ADDR_W 8
`define ESD_OVS 8
`define ESD_SLOW_DIV 3'h7

`define ESD_OFS_STATUS 8'h00
`define ESD_OFS_LMATRIX 8'h04
`define ESD_OFS_MATRIX 8'h08
`define ESD_OFS_SOFT 8'h0c
`define ESD_OFS_FINE_THR 8'h10
`define ESD_OFS_COARSE_THR 8'h14
`define ESD_OFS_LEVEL0 8'h20
`define ESD_OFS_HYST0 8'h24
`define ESD_CH_STRIDE 8'h08

`define ESD_LM_FIELD_W 3
`define ESD_MX_FIELD_W 5
`define ESD_LMATRIX_RST 12'h000
`define ESD_MATRIX_RST 20'h00000
`define ESD_THR_RST 16'h0000
`define ESD_HYST_RST 16'h0000

`endif

// >>> esd_pkg.sv
// types of the event source block
package esd_pkg;

  typedef enum logic [1:0] {
    ESD_EDGE_RISING = 2'h0,
    ESD_EDGE_FALLING = 2'h1,
    ESD_EDGE_BOTH = 2'h3,
    ESD_EDGE_NONE = 2'h2
  } esd_edge_type;

  typedef enum logic [2:0] {
    ESD_SRC_INVALID = 3'h0,
    ESD_SRC_FINE = 3'h1,
    ESD_SRC_COARSE = 3'h2,
    ESD_SRC_GENERAL_A = 3'h3,
    ESD_SRC_STAR = 3'h4,
    ESD_SRC_BP_TRIG0 = 3'h5,
    ESD_SRC_BP_TRIG1 = 3'h6,
    ESD_SRC_SOFTWARE = 3'h7
  } esd_src_type;

  function automatic logic esd_edge_match(input logic [1:0] sel, input logic rise, input logic fall);
    logic m;
    m = 1'b0;
    case (sel)
      2'h0: m = rise;
      2'h1: m = fall;
      2'h3: m = rise | fall;
      default: m = 1'b0;
    endcase
    return m;
  endfunction

endpackage

// >>> esd_level_det.sv
// per-channel level crossing detector with arm hysteresis
`include "esd_consts.svh"

module esd_level_det
  import esd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // sample stream
  input wire logic signed [`ESD_SW-1:0] sample,
  input wire logic sample_valid,
  input wire logic acq_running,
  // settings
  input wire logic signed [`ESD_SW-1:0] threshold,
  input wire logic [`ESD_SW-1:0] hysteresis,
  // events and state
  output logic rise_evt,
  output logic fall_evt,
  output logic rise_armed,
  output logic fall_armed
);

  logic signed [`ESD_SW+1:0] s_x;
  logic signed [`ESD_SW+1:0] thr_x;
  logic signed [`ESD_SW+1:0] rise_lvl;
  logic signed [`ESD_SW+1:0] fall_lvl;
  logic rise_fire;
  logic fall_fire;
  logic rise_armed_q;
  logic fall_armed_q;
  logic rise_q;
  logic fall_q;

  // widened so threshold +/- margin never wraps
  assign s_x = {{2{sample[`ESD_SW-1]}}, sample};
  assign thr_x = {{2{threshold[`ESD_SW-1]}}, threshold};
  assign rise_lvl = thr_x - $signed({2'h0, hysteresis});
  assign fall_lvl = thr_x + $signed({2'h0, hysteresis});

  // fire only from an arm taken on an earlier sample
  assign rise_fire = sample_valid && acq_running && rise_armed_q && (s_x >= thr_x);
  assign fall_fire = sample_valid && acq_running && fall_armed_q && (s_x <= thr_x);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rise_armed_q <= 1'b0;
    else if (!acq_running)
      rise_armed_q <= 1'b0;
    else if (rise_fire)
      rise_armed_q <= 1'b0;
    else if (sample_valid && (s_x <= rise_lvl))
      rise_armed_q <= 1'b1;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      fall_armed_q <= 1'b0;
    else if (!acq_running)
      fall_armed_q <= 1'b0;
    else if (fall_fire)
      fall_armed_q <= 1'b0;
    else if (sample_valid && (s_x >= fall_lvl))
      fall_armed_q <= 1'b1;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      rise_q <= rise_fire;
      fall_q <= fall_fire;
    end
  end

  assign rise_evt = rise_q;
  assign fall_evt = fall_q;
  assign rise_armed = rise_armed_q;
  assign fall_armed = fall_armed_q;

endmodule

// >>> esd_event_sources_properties.sv
// port assertions for the event source block
`include "esd_consts.svh"

module esd_event_sources_properties
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ESD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // level path
  input wire logic [`ESD_NCH*`ESD_SW-1:0] chan_samples,
  input wire logic acq_running,
  input wire logic [`ESD_NCH-1:0] chan_level_rise,
  input wire logic [`ESD_NCH-1:0] chan_level_fall,
  input wire logic level_matrix_rise,
  input wire logic level_matrix_fall,
  input wire logic pulse_level_matrix_rise,
  input wire logic pulse_level_matrix_fall,
  // combiner
  input wire logic matrix_rise,
  input wire logic matrix_fall,
  input wire logic [1:0] matrix_input
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] thr0_q;
  logic [19:0] mx_q;
  logic sw_en;
  logic wr;

  assign wr = psel && penable && pwrite;

  // ----------------------------------------
  // shadows of written settings
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      thr0_q <= 16'h0000;
    else if (wr && paddr == `ESD_OFS_LEVEL0)
      thr0_q <= pwdata[15:0];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      mx_q <= 20'h00000;
    else if (wr && paddr == `ESD_OFS_MATRIX)
      mx_q <= pwdata[19:0];
  end

  // equal edge bits mean rising or both
  always_comb
  begin
    sw_en = 1'b0;
    for (int m = 0; m < 4; m++)
      if (mx_q[5*m+:3] == 3'h7 && mx_q[5*m+4] == mx_q[5*m+3])
        sw_en = 1'b1;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  chk_ready_now: assert property (pready == (psel && penable) && (!pslverr || pready))
    else $error("apb answer wrong");
  chk_quiet_chan: assert property (!acq_running |=> chan_level_rise == 4'h0 && chan_level_fall == 4'h0)
    else $error("level event while idle");
  chk_quiet_comb: assert property (!acq_running [*2] |=> !level_matrix_rise && !level_matrix_fall)
    else $error("combined event while idle");
  chk_rise_cross: assert property (chan_level_rise[0] |-> $signed($past(chan_samples[15:0])) >= $signed($past(thr0_q)))
    else $error("rise below threshold");
  chk_comb_source: assert property (level_matrix_rise |-> $past(|chan_level_rise))
    else $error("combined rise without channel rise");
  chk_pulse_same: assert property ({pulse_level_matrix_rise, pulse_level_matrix_fall} == {level_matrix_rise, level_matrix_fall})
    else $error("pulse copy differs");
  chk_idle_input: assert property (!(matrix_rise || matrix_fall) |-> matrix_input == 2'h0)
    else $error("winner shown without event");
  chk_soft_event: assert property (wr && paddr == `ESD_OFS_SOFT && pwdata[0] && sw_en |-> ##2 matrix_rise)
    else $error("software event lost");

  cover property (level_matrix_rise);
  cover property (matrix_rise && matrix_input == 2'h3);
  cover property (pslverr);
endmodule

// >>> esd_consumer_model.sv
// pulse generator and function module stand-in fed by the block
module esd_consumer_model
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // events
  input wire logic pulse_level_matrix_rise,
  input wire logic pulse_level_matrix_fall,
  input wire logic matrix_rise,
  input wire logic matrix_fall,
  // pulse output and counts
  output logic pulse_out_q,
  output int n_pulse,
  output int n_matrix
);
  timeunit 1ns;
  timeprecision 100ps;

  // pulse output toggles on every combined level event
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pulse_out_q <= 1'b0;
      n_pulse <= 0;
    end
    else if (pulse_level_matrix_rise || pulse_level_matrix_fall)
    begin
      pulse_out_q <= ~pulse_out_q;
      n_pulse <= n_pulse + 1;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      n_matrix <= 0;
    else if (matrix_rise || matrix_fall)
      n_matrix <= n_matrix + 1;
  end
endmodule

// >>> esd_event_sources_tb.sv
// self-checking bench for the event source block
`include "esd_consts.svh"

module esd_event_sources_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [63:0] chan_samples = 64'h0;
  logic [3:0] chan_valid = 4'h0;
  logic acq_running = 1'b0;
  logic [7:0] fine_timing_port = 8'h00;
  logic coarse_timing_port = 1'b0;
  logic general_port_a = 1'b0;
  logic backplane_star_source = 1'b0;
  logic backplane_trig0_source = 1'b0;
  logic backplane_trig1_source = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, pulse_out_q;
  logic [15:0] fine_threshold, coarse_threshold;
  logic [3:0] chan_level_rise, chan_level_fall;
  logic level_matrix_rise, level_matrix_fall, pulse_level_matrix_rise, pulse_level_matrix_fall;
  logic matrix_rise, matrix_fall;
  logic [2:0] fine_subsample_pos;
  logic [1:0] matrix_input;
  int n_pulse, n_matrix, thr[4], hyst[4];
  int n_fail = 0;
  int n_checks = 0;
  int n_lm = 0;
  int seed = 32'h41f8e743;
  logic [1:0] edg[4] = '{2'h2, 2'h2, 2'h2, 2'h2};
  logic [1:0] etab[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [3:0] en = 4'h0, er = 4'h0, ef = 4'h0, ar = 4'h0, af = 4'h0;
  logic lr = 1'b0, lf = 1'b0, mon = 1'b0;

  always #12.5 clk = ~clk;

  esd_event_sources u_esd_event_sources (.*);
  esd_consumer_model u_esd_consumer_model (.*);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input bit ok, input string m);
    n_checks++;
    if (!ok)
    begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
      n++;
    end
    r = prdata;
    e = pslverr;
    check(n == 0, "apb wait states");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic drive_src(input int s, input logic v);
    logic [31:0] r;
    logic e;
    case (s)
      1: fine_timing_port <= {8{v}};
      2: coarse_timing_port <= v;
      3: general_port_a <= v;
      4: backplane_star_source <= v;
      5: backplane_trig0_source <= v;
      6: backplane_trig1_source <= v;
      default: if (v) apb(`ESD_OFS_SOFT, 1'b1, 32'h1, r, e);
    endcase
  endtask

  // slow ports are seen only every eighth clock, so allow 24
  task automatic expect_evt(input logic xr, input logic xf, input logic [1:0] idx);
    bit found;
    found = 0;
    for (int i = 0; i < 24 && !found; i++)
    begin
      @(posedge clk);
      found = ((matrix_rise | matrix_fall) === 1'b1);
    end
    if (xr | xf)
      check(found && matrix_rise === xr && matrix_fall === xf && matrix_input === idx, "matrix event");
    else
      check(!found, "stray matrix event");
    repeat (16) @(posedge clk);
  endtask

  // ----------------------------------------
  // level detector and level combiner model
  // ----------------------------------------
  always @(posedge clk)
  begin : model
    int s;
    logic [3:0] nr, nf;
    logic mr, mf;
    if (reset)
    begin
      {er, ef, ar, af, lr, lf} = '0;
    end
    else
    begin
      if (mon)
        check(chan_level_rise === er && chan_level_fall === ef, "channel event");
      if (mon)
        check({level_matrix_rise, level_matrix_fall, pulse_level_matrix_rise, pulse_level_matrix_fall} === {lr, lf, lr, lf}, "combined event");
      n_lm += int'(lr | lf);
      {mr, mf, nr, nf} = '0;
      for (int c = 0; c < 4; c++)
      begin
        mr |= en[c] && er[c] && (edg[c][0] == edg[c][1]);
        mf |= en[c] && ef[c] && edg[c][0];
        s = $signed(chan_samples[16*c+:16]);
        if (!acq_running)
          {ar[c], af[c]} = 2'b00;
        else if (chan_valid[c])
        begin
          nr[c] = ar[c] && s >= thr[c];
          nf[c] = af[c] && s <= thr[c];
          ar[c] = !nr[c] && (ar[c] || s <= thr[c] - hyst[c]);
          af[c] = !nf[c] && (af[c] || s >= thr[c] + hyst[c]);
        end
      end
      {er, ef, lr, lf} = {nr, nf, mr, mf};
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    logic [31:0] rd;
    logic eb;
    logic [11:0] lm;
    logic [19:0] mx;
    logic [7:0] rofs[6];
    int k, n0, nexp;
    rofs = '{`ESD_OFS_LMATRIX, `ESD_OFS_MATRIX, `ESD_OFS_FINE_THR, `ESD_OFS_COARSE_THR, `ESD_OFS_LEVEL0, `ESD_OFS_HYST0};
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    mon <= 1'b1;
    foreach (rofs[i])
    begin
      apb(rofs[i], 1'b0, 32'h0, rd, eb);
      check(rd === 32'h0 && eb === 1'b0, "reset value");
    end
    apb(8'h18, 1'b1, 32'hffffffff, rd, eb);
    apb(8'h18, 1'b0, 32'h0, rd, eb);
    check(eb === 1'b1 && rd === 32'h0, "unmapped");
    apb(`ESD_OFS_FINE_THR, 1'b1, 32'h0000a5c3, rd, eb);
    apb(`ESD_OFS_COARSE_THR, 1'b1, 32'h00003c5a, rd, eb);
    // second write lands on the edge the task returned on
    @(posedge clk);
    check(fine_threshold === 16'ha5c3 && coarse_threshold === 16'h3c5a, "thresholds");
    $display("test registers done");
    for (int r = 0; r < 4; r++)
    begin
      acq_running <= 1'b0;
      repeat (4) @(posedge clk);
      lm = 12'h000;
      for (int c = 0; c < 4; c++)
      begin
        thr[c] = $random(seed) % 1000;
        hyst[c] = $random(seed) & 511; // margin kept positive
        edg[c] = etab[(r + c) % 4];
        en[c] = (c == 0) || ($random(seed) & 1);
        lm[3*c+:3] = {edg[c], en[c]};
        apb(`ESD_OFS_LEVEL0 + 8'(8 * c), 1'b1, {16'h0, 16'(thr[c])}, rd, eb);
        apb(`ESD_OFS_HYST0 + 8'(8 * c), 1'b1, {16'h0, 16'(hyst[c])}, rd, eb);
      end
      apb(`ESD_OFS_LMATRIX, 1'b1, {20'h0, lm}, rd, eb);
      apb(`ESD_OFS_LEVEL0, 1'b0, 32'h0, rd, eb);
      check(rd === {16'h0, 16'(thr[0])}, "level readback");
      for (int i = 0; i < 300; i++)
      begin
        for (int c = 0; c < 4; c++)
          chan_samples[16*c+:16] <= 16'($random(seed) % 3000);
        chan_valid <= 4'($random(seed));
        acq_running <= (i < 140 || i >= 160);
        @(posedge clk);
      end
      $display("test level round %0d done", r);
    end
    acq_running <= 1'b0;
    repeat (4) @(posedge clk);
    check(n_pulse == n_lm && n_matrix == 0, "consumer counts");
    n0 = n_matrix;
    nexp = 0;
    for (int s = 1; s < 7; s++)
      for (int i = 0; i < 4; i++)
      begin
        k = (s + i) % 4;
        mx = 20'h0;
        mx[5*k+:5] = {etab[i], 3'(s)};
        apb(`ESD_OFS_MATRIX, 1'b1, {12'h0, mx}, rd, eb);
        drive_src(s, 1'b1);
        expect_evt(etab[i][0] == etab[i][1], 1'b0, 2'(k));
        drive_src(s, 1'b0);
        expect_evt(1'b0, etab[i][0], 2'(k));
        nexp += (etab[i] == 2'h3) ? 2 : (etab[i] == 2'h2) ? 0 : 1;
      end
    apb(`ESD_OFS_MATRIX, 1'b1, 32'h000f8000 & {12'h0, 5'b00111, 15'h0}, rd, eb);
    drive_src(7, 1'b1);
    expect_evt(1'b1, 1'b0, 2'h3);
    check(n_matrix - n0 == nexp + 1, "matrix count");
    $display("test matrix sources done");
    apb(`ESD_OFS_MATRIX, 1'b1, {12'h0, {4{5'b11000}}}, rd, eb);
    for (int s = 1; s < 8; s++)
    begin
      drive_src(s, 1'b1);
      expect_evt(1'b0, 1'b0, 2'h0);
      drive_src(s, 1'b0);
    end
    // first transition at bit 4; the all-ones word after it adds no edge
    fine_timing_port <= 8'hf0;
    @(posedge clk);
    fine_timing_port <= 8'hff;
    @(posedge clk);
    check(fine_subsample_pos === 3'h4, "fine position");
    fine_timing_port <= 8'h00;
    $display("test invalid inputs done");
    apb(`ESD_OFS_MATRIX, 1'b1, {12'h0, 5'b11101, 5'b11100, 5'b11011, 5'b11010}, rd, eb);
    for (int m = 0; m < 4; m++)
    begin
      for (int j = m; j < 4; j++)
        drive_src(2 + j, 1'b1);
      expect_evt(1'b1, 1'b0, 2'(m));
      for (int j = m; j < 4; j++)
        drive_src(2 + j, 1'b0);
      expect_evt(1'b0, 1'b1, 2'(m));
    end
    $display("test priority done");
    give_verdict();
  end

  // about 3500 cycles are needed; allow 16000
  initial
  begin
    #400000;
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule

bind esd_event_sources esd_event_sources_properties u_esd_event_sources_properties (.*);
